// File: hw/sarf_pkg.sv
// Package for the serial converter readout frame block.
// Assumes a 40 MHz reference clock; all frame pins are sampled from outside.
package sarf_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned RESULT_W      = 12;
  localparam int unsigned LEAD_ZEROS    = 3;
  localparam logic [4:0]  FRAME_EDGES   = 5'h10;
  localparam logic [4:0]  TRACK_RISE    = 5'h0d;
  localparam logic [4:0]  SHUT_FIRST    = 5'h02;
  localparam logic [4:0]  SHUT_LAST     = 5'h0a;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS      = 25000;
  localparam int unsigned ACQ_INTERVAL_PS    = 350000;
  localparam int unsigned QUIET_INTERVAL_PS  = 50000;
  localparam int unsigned ACQ_INTERVAL_CYC   = (ACQ_INTERVAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned QUIET_INTERVAL_CYC = (QUIET_INTERVAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FRAME = 4'b0010,
    ST_DONE  = 4'b0100,
    ST_ABORT = 4'b1000
  } sarf_state_e;

  // Clean edge events and the select low level recovered from the sampled link pins.
  typedef struct packed {
    logic sel_fall;
    logic sel_rise;
    logic sel_low;
    logic clk_fall;
    logic clk_rise;
  } sarf_link_s;

endpackage

// File: hw/sarf_edge_sync.sv
// Synchroniser and edge finder for the frame select and serial clock pins.
// Assumes both pins are asynchronous to the reference clock.
`timescale 1ns/1ps
`default_nettype none
module sarf_edge_sync (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                nrst_i,
  // Pins
  input  wire logic                sel_n_i,
  input  wire logic                sclk_i,
  // Events
  output var sarf_pkg::sarf_link_s link_o
);

  logic [1:0] sel_meta_ff;
  logic [1:0] clk_meta_ff;
  logic       sel_last_ff;
  logic       clk_last_ff;

  // Select idles high, so the chain resets high to avoid a false frame start.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_meta_ff <= 2'h3;
      clk_meta_ff <= 2'h0;
      sel_last_ff <= 1'b1;
      clk_last_ff <= 1'b0;
    end else begin
      sel_meta_ff <= {sel_meta_ff[0], sel_n_i};
      clk_meta_ff <= {clk_meta_ff[0], sclk_i};
      sel_last_ff <= sel_meta_ff[1];
      clk_last_ff <= clk_meta_ff[1];
    end
  end

  wire sel_fall = sel_last_ff & ~sel_meta_ff[1];
  wire sel_rise = ~sel_last_ff & sel_meta_ff[1];
  wire sel_low  = ~sel_meta_ff[1];
  wire clk_fall = clk_last_ff & ~clk_meta_ff[1];
  wire clk_rise = ~clk_last_ff & clk_meta_ff[1];

  // One driver for the whole struct keeps every tool happy with the variable port.
  assign link_o = '{sel_fall: sel_fall,
                    sel_rise: sel_rise,
                    sel_low:  sel_low,
                    clk_fall: clk_fall,
                    clk_rise: clk_rise};

endmodule // sarf_edge_sync
`default_nettype wire

// File: hw/sarf_readout.sv
// Frame control and serial result shifter of a 12-bit converter.
// Assumes the analog core supplies a result and the pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module sarf_readout (
  // Clock and reset
  input  wire logic                          REF_CLK_I,
  input  wire logic                          NRST_I,
  // Serial link pins
  input  wire logic                          SEL_N_I,
  input  wire logic                          SCLK_I,
  output logic                               SERIAL_RESULT_OUT_O,
  output logic                               SERIAL_RESULT_OE_N_O,
  // Converter core
  input  wire logic [sarf_pkg::RESULT_W-1:0] RESULT_I,
  output logic                               HOLD_O,
  output logic                               SHUTDOWN_O
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  sarf_pkg::sarf_link_s link;

  sarf_edge_sync u_sync (
    .ref_clk_i (REF_CLK_I),
    .nrst_i    (NRST_I),
    .sel_n_i   (SEL_N_I),
    .sclk_i    (SCLK_I),
    .link_o    (link)
  );

  // ----------------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------------
  sarf_pkg::sarf_state_e state_ff;
  sarf_pkg::sarf_state_e nxt_state;
  logic [4:0]            fall_cnt_ff;
  logic [4:0]            rise_cnt_ff;
  logic [15:0]           shift_ff;
  logic                  out_ff;
  logic                  oe_n_ff;
  logic                  hold_ff;
  logic                  shut_ff;

  wire in_frame   = (state_ff == sarf_pkg::ST_FRAME);
  wire frame_fall = in_frame & link.clk_fall;
  wire frame_rise = in_frame & link.clk_rise;
  wire last_fall  = frame_fall & (fall_cnt_ff == sarf_pkg::FRAME_EDGES - 5'h01);
  wire track_rise = frame_rise & (rise_cnt_ff == sarf_pkg::TRACK_RISE - 5'h01);
  wire early_end  = in_frame & link.sel_rise;
  // A rise once the tenth falling edge has been counted is a late abort and keeps normal mode.
  wire shut_abort = early_end & (fall_cnt_ff >= sarf_pkg::SHUT_FIRST) & (fall_cnt_ff < sarf_pkg::SHUT_LAST);
  wire [15:0] load_word = {{sarf_pkg::LEAD_ZEROS{1'b0}}, RESULT_I, 1'b0};

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sarf_pkg::ST_IDLE:  if (link.sel_fall) nxt_state = sarf_pkg::ST_FRAME;
      sarf_pkg::ST_FRAME: begin
        if (link.sel_rise) begin
          nxt_state = sarf_pkg::ST_IDLE;
        end else if (last_fall) begin
          nxt_state = sarf_pkg::ST_DONE;
        end
      end
      sarf_pkg::ST_DONE:  if (!link.sel_low) nxt_state = sarf_pkg::ST_IDLE;
      sarf_pkg::ST_ABORT: nxt_state = sarf_pkg::ST_IDLE;
      default:            nxt_state = sarf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_ff <= sarf_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // Edge counters
  // ----------------------------------------------------------------------
  // edge counting
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fall_cnt_ff <= 5'h00;
      rise_cnt_ff <= 5'h00;
    end else if (link.sel_fall && state_ff == sarf_pkg::ST_IDLE) begin
      fall_cnt_ff <= 5'h00;
      rise_cnt_ff <= 5'h00;
    end else begin
      if (frame_fall) fall_cnt_ff <= fall_cnt_ff + 5'h01;
      if (frame_rise) rise_cnt_ff <= rise_cnt_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------------
  // The first zero is driven at select fall; each falling edge presents the
  // next bit, so the host captures it on the following fall.
  // word layout
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      shift_ff <= 16'h0000;
      out_ff   <= 1'b0;
    end else if (link.sel_fall && state_ff == sarf_pkg::ST_IDLE) begin
      shift_ff <= load_word;
      out_ff   <= 1'b0;
    end else if (frame_fall) begin
      shift_ff <= {shift_ff[14:0], 1'b0};
      out_ff   <= shift_ff[14];
    end
  end

  // float at end or select rise
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      oe_n_ff <= 1'b1;
    end else if (link.sel_fall && state_ff == sarf_pkg::ST_IDLE) begin
      oe_n_ff <= 1'b0;
    end else if (last_fall || early_end || !in_frame) begin
      oe_n_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Sampler and power mode
  // ----------------------------------------------------------------------
  // track to hold
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hold_ff <= 1'b0;
    end else if (link.sel_fall && state_ff == sarf_pkg::ST_IDLE) begin
      hold_ff <= 1'b1;
    end else if (track_rise || early_end) begin
      hold_ff <= 1'b0;
    end
  end

  // Shutdown lasts until the next select fall; a rise before edge two is
  // treated as noise and leaves the mode unchanged.
  // shutdown abort
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      shut_ff <= 1'b0;
    end else if (shut_abort) begin
      shut_ff <= 1'b1;
    end else if (link.sel_fall && state_ff == sarf_pkg::ST_IDLE) begin
      shut_ff <= 1'b0;
    end
  end

  assign SERIAL_RESULT_OUT_O  = out_ff;
  assign SERIAL_RESULT_OE_N_O = oe_n_ff;
  assign HOLD_O               = hold_ff;
  assign SHUTDOWN_O           = shut_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  float_idle_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_ff == sarf_pkg::ST_IDLE && !link.sel_fall) |=> SERIAL_RESULT_OE_N_O)
    else $error("output driven outside a frame");
  start_drive_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_ff == sarf_pkg::ST_IDLE && link.sel_fall) |=> (!SERIAL_RESULT_OE_N_O && HOLD_O))
    else $error("frame start did not drive and hold");
  end_float_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (last_fall || early_end) |=> SERIAL_RESULT_OE_N_O)
    else $error("output not floated at frame end");
  track_return_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    track_rise |=> (!HOLD_O && rise_cnt_ff == sarf_pkg::TRACK_RISE))
    else $error("hold not released on rise thirteen");
  lead_zero_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (frame_fall && fall_cnt_ff < 5'h02) |=> !SERIAL_RESULT_OUT_O)
    else $error("leading zero missing");
  msb_first_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_ff == sarf_pkg::ST_IDLE && link.sel_fall) |=> shift_ff[12:1] == $past(RESULT_I))
    else $error("result bit order wrong");
  bit_on_fall_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (!frame_fall && !(state_ff == sarf_pkg::ST_IDLE && link.sel_fall)) |=> $stable(SERIAL_RESULT_OUT_O))
    else $error("output bit changed off a falling edge");
  shut_enter_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    shut_abort |=> (SHUTDOWN_O && SERIAL_RESULT_OE_N_O))
    else $error("shutdown not entered");
  late_abort_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (early_end && fall_cnt_ff >= sarf_pkg::SHUT_LAST) |=> (!SHUTDOWN_O && SERIAL_RESULT_OE_N_O))
    else $error("late abort changed mode");
  edge_count_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    frame_fall |=> fall_cnt_ff == $past(fall_cnt_ff) + 5'h01)
    else $error("falling edge not counted");

endmodule // sarf_readout
`default_nettype wire

// File: sim/sarf_host_model.sv
// Serial host model: frames select and clock, captures result bits.
// Assumes it is stepped on the falling edge of the reference clock.
`timescale 1ns/1ps
`default_nettype none
module sarf_host_model (
  // Reference clock
  input  wire logic clk_i,
  // Link pins
  output logic      sel_n_o,
  output logic      sclk_o,
  input  wire logic out_i,
  input  wire logic oe_n_i,
  // Observed mode
  input  wire logic hold_i
);
  logic        last_ff = 1'b0;
  logic        line;
  logic [15:0] word;
  logic        h13;
  logic        h14;
  logic        float_seen;

  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b1;
  end

  // A released line shows the inverse of its last level, so a stale bit never passes.
  always @(posedge clk_i) if (!oe_n_i) last_ff <= out_i;
  assign line = oe_n_i ? ~last_ff : out_i;

  // ----------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------
  // select low, clock idle
  task automatic frame(input int n);
    word = 16'h0000;
    float_seen = 1'b0;
    sel_n_o = 1'b0;
    repeat (8) @(negedge clk_i);
    for (int k = 1; k <= n; k++) begin
      word = {word[14:0], line};
      float_seen = float_seen | oe_n_i;
      if (k == 13) h13 = hold_i;
      if (k == 14) h14 = hold_i;
      sclk_o = 1'b0;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat ((k == 13) ? sarf_pkg::ACQ_INTERVAL_CYC : 4) @(negedge clk_i);
    end
  endtask

  task automatic end_frame;
    sel_n_o = 1'b1;
    repeat (sarf_pkg::ACQ_INTERVAL_CYC + sarf_pkg::QUIET_INTERVAL_CYC) @(negedge clk_i);
  endtask

  // Clock activity with select high, for the idle case only.
  task automatic spin(input int n);
    repeat (2 * n) begin
      sclk_o = ~sclk_o;
      repeat (4) @(negedge clk_i);
    end
  endtask
endmodule // sarf_host_model
`default_nettype wire

// File: sim/sarf_readout_tb.sv
// Testbench for the readout frame block: full frames, idle clocks, aborts.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module sarf_readout_tb;
  logic                          ref_clk = 1'b0;
  logic                          rst_n   = 1'b0;
  logic [sarf_pkg::RESULT_W-1:0] result  = 12'h000;
  wire                           sel_n;
  wire                           sclk;
  wire                           out;
  wire                           oe_n;
  wire                           hold;
  wire                           shut;
  int                            num_errors = 0;
  int                            num_checks = 0;
  int                            cuts [6] = '{1, 11, 15, 2, 10, 9};

  sarf_readout uut (
    .REF_CLK_I           (ref_clk),
    .NRST_I              (rst_n),
    .SEL_N_I             (sel_n),
    .SCLK_I              (sclk),
    .SERIAL_RESULT_OUT_O (out),
    .SERIAL_RESULT_OE_N_O(oe_n),
    .RESULT_I            (result),
    .HOLD_O              (hold),
    .SHUTDOWN_O          (shut)
  );
  sarf_host_model host (.clk_i(ref_clk), .sel_n_o(sel_n), .sclk_o(sclk), .out_i(out), .oe_n_i(oe_n), .hold_i(hold));

  initial forever #12.5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_oe(input logic v, input string nm);
    for (int i = 0; i < 10 && oe_n !== v; i++) @(negedge ref_clk);
    `CHK(nm, v, oe_n)
    if (oe_n !== v) close_out();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_full;
    for (int i = 0; i < 2; i++) begin
      result = i ? 12'h3f1 : 12'ha5c;
      host.frame(16);
      `CHK("word", {3'h0, result, 1'b0}, host.word)
      `CHK("driven", 1'b0, host.float_seen)
      `CHK("hold13", 1'b1, host.h13)
      `CHK("hold14", 1'b0, host.h14)
      wait_oe(1'b1, "oe16");
      repeat (16) @(negedge ref_clk);
      `CHK("norestart", 1'b1, oe_n)
      `CHK("normal", 1'b0, shut)
      host.end_frame();
    end
    $display("t_full done");
  endtask

  task automatic t_idle;
    host.spin(6);
    `CHK("idle_oe", 1'b1, oe_n)
    `CHK("idle_hold", 1'b0, hold)
    $display("t_idle done");
  endtask

  task automatic t_abort;
    foreach (cuts[j]) begin
      result = 12'hc35;
      host.frame(cuts[j]);
      host.end_frame();
      `CHK("part", {3'h0, result, 1'b0} >> (16 - cuts[j]), host.word)
      `CHK("cut_oe", 1'b1, oe_n)
      `CHK("cut_hold", 1'b0, hold)
      `CHK("shut", logic'(cuts[j] >= 2 && cuts[j] < 10), shut)
    end
    $display("t_abort done");
  endtask

  initial begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_full();
    t_idle();
    t_abort();
    close_out();
  end
endmodule // sarf_readout_tb
`default_nettype wire
